// File: design/spi_fifo_pkg.sv
package spi_fifo_pkg;
    localparam int PADDR_W = 12;
    localparam int RING_DEPTH_DEF = 128;
    // Register indices; byte address is four times the index
    localparam logic [7:0] IDX_MAIN = 8'h9a;
    localparam logic [7:0] IDX_DATA = 8'h9b;
    localparam logic [7:0] IDX_RCON = 8'h9c;
    localparam logic [7:0] IDX_TCON = 8'h9d;
    localparam logic [7:0] IDX_START = 8'h9e;
    localparam logic [7:0] IDX_END = 8'h9f;
    localparam logic [7:0] IDX_AIE = 8'ha6;
    localparam logic [7:0] IDX_AUX_INTERRUPT_STATUS = 8'ha7;
    // Main control fields
    localparam int MC_DIV_LSB = 5;
    localparam int MC_FIFO_BIT = 4;
    localparam int MC_ORDER_BIT = 3;
    localparam int MC_CPHA_BIT = 1;
    localparam int MC_CPOL_BIT = 0;
    // Receive and transmit control fields
    localparam int RC_FLUSH_BIT = 7;
    localparam int TC_FLUSH_BIT = 7;
    localparam int TC_SCLK_EN_BIT = 5;
    localparam int TC_DRV_EN_BIT = 3;
    // Aux interrupt bits
    localparam int AI_RX_BIT = 2;
    localparam int AI_TX_BIT = 3;
    localparam logic [7:0] RING_MSB = 8'h80;
    localparam logic [7:0] CTL_RST = 8'h00;
    // Half period of the serial clock is this shifted by the divider code
    localparam logic [7:0] HALF_BASE = 8'h01;
    typedef enum logic
    {
        st_idle = 1'b0,
        st_shift = 1'b1
    } state_type;
endpackage

// File: design/spi_fifo_transfer_engine.sv
`timescale 1ns/1ps
// Summary of operation
// - FIFO mode: data writes go into ring
// - First queued bytes move to holding stage
// - Each shifted byte stores one received byte
// - Write-in pointer advances, stops before read
// - Ring size two to one hundred twenty-eight
// - Holding and shift registers add two bytes
// - Slave select stays asserted between bytes
// - Transmit flag when holding stage empty
// - Receive flag when byte ready
// - Transmit control enables data, clock drivers
// - Transmit flag held while count at level
// - Value 83h flushes receive, level four
// - Divider code picks serial clock rate
// - Ring spans start to end address
// - Status reports receive 04h, transmit 08h
// - Main control write resets pointers, counters
// - Ring address MSB forced, end above start
// - Receive flush: read pointer to write-in
// - Transmit flush: transmit to write pointer
module spi_fifo_transfer_engine #(
    parameter int RING_DEPTH = spi_fifo_pkg::RING_DEPTH_DEF
)(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic ce,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [spi_fifo_pkg::PADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic pready,
    output logic [31:0] prdata,
    output logic pslverr,
    output logic sclk,
    output logic sclk_oe,
    output logic mosi,
    output logic mosi_oe,
    input wire logic miso,
    output logic ss_n,
    output logic transmit_level_irq,
    output logic receive_level_irq
);
    import spi_fifo_pkg::*;
    localparam int IW = $clog2(RING_DEPTH);
    typedef logic [IW-1:0] idx_type;

    logic [7:0] main_ctl, rcon, tcon, start_a, end_a, aux_interrupt_enable;
    idx_type wr_ptr, tx_ptr, in_ptr, rx_ptr;
    idx_type nxt_wr, nxt_tx, nxt_in, nxt_rx, start_i, end_i, last_i;
    logic [7:0] ring [RING_DEPTH];
    logic [7:0] tx_count, rx_count, hold_d, rx_last, sh, rv, div_cnt;
    logic [7:0] half, rx_byte, samp_val, tx_lvl, rx_lvl, aux_interrupt_status, rd_val;
    logic [2:0] bit_cnt;
    logic hold_v, sclk_q, fifo, cpha, order, mapped;
    logic sel_main, sel_data, sel_rcon, sel_tcon, sel_start, sel_end;
    logic sel_aie, sel_stat;
    logic acc, wr, rd, w_main, w_data, w_rcon, w_tcon, r_data;
    logic tx_flush, rx_flush, push, direct_load, move, start_byte;
    logic rx_room, tick, lead, trail, samp, shift_ev, done, store, pop;
    logic tx_flag, rx_flag;
    state_type state;

    // Ring occupies start up to end minus one
    function automatic idx_type adv(input idx_type p);
        idx_type q;
        q = p + idx_type'(1);
        return (q == end_i) ? start_i : q;
    endfunction

    ////////////////////////////////////////////////////////////////////
    // Register bus
    assign acc = psel & penable & ce;
    assign wr = acc & pwrite;
    assign rd = acc & ~pwrite;
    assign pready = ce;
    assign pslverr = psel & penable & ~mapped;

    always_comb
    begin
        sel_main = 1'b0;
        sel_data = 1'b0;
        sel_rcon = 1'b0;
        sel_tcon = 1'b0;
        sel_start = 1'b0;
        sel_end = 1'b0;
        sel_aie = 1'b0;
        sel_stat = 1'b0;
        if (paddr[1:0] != 2'h0 || paddr[11:10] != 2'h0)
            mapped = 1'b0;
        else if (paddr[9:2] == IDX_MAIN)
            sel_main = 1'b1;
        else if (paddr[9:2] == IDX_DATA)
            sel_data = 1'b1;
        else if (paddr[9:2] == IDX_RCON)
            sel_rcon = 1'b1;
        else if (paddr[9:2] == IDX_TCON)
            sel_tcon = 1'b1;
        else if (paddr[9:2] == IDX_START)
            sel_start = 1'b1;
        else if (paddr[9:2] == IDX_END)
            sel_end = 1'b1;
        else if (paddr[9:2] == IDX_AIE)
            sel_aie = 1'b1;
        else if (paddr[9:2] == IDX_AUX_INTERRUPT_STATUS)
            sel_stat = 1'b1;
        mapped = sel_main | sel_data | sel_rcon | sel_tcon | sel_start
            | sel_end | sel_aie | sel_stat;
    end

    assign w_main = wr & sel_main;
    assign w_data = wr & sel_data;
    assign w_rcon = wr & sel_rcon;
    assign w_tcon = wr & sel_tcon;
    assign r_data = rd & sel_data;
    assign tx_flush = w_tcon & pwdata[TC_FLUSH_BIT];
    assign rx_flush = w_rcon & pwdata[RC_FLUSH_BIT];

    // Flush bits are write-only and never stored
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            main_ctl <= CTL_RST;
            rcon <= CTL_RST;
            tcon <= CTL_RST;
            start_a <= CTL_RST;
            end_a <= CTL_RST;
            aux_interrupt_enable <= CTL_RST;
        end
        else if (ce)
        begin
            if (w_main)
                main_ctl <= pwdata[7:0];
            if (w_rcon)
                rcon <= {1'b0, pwdata[6:0]};
            if (w_tcon)
                tcon <= {1'b0, pwdata[6:0]};
            if (wr & sel_start)
                start_a <= pwdata[7:0];
            if (wr & sel_end)
                end_a <= pwdata[7:0];
            if (wr & sel_aie)
                aux_interrupt_enable <= pwdata[7:0];
        end
    end

    always_comb
    begin
        rd_val = 8'h00;
        if (sel_main)
            rd_val = main_ctl;
        else if (sel_data)
            rd_val = fifo ? ring[rx_ptr] : rx_last;
        else if (sel_rcon)
            rd_val = rcon;
        else if (sel_tcon)
            rd_val = tcon;
        else if (sel_start)
            rd_val = start_a | RING_MSB;
        else if (sel_end)
            rd_val = end_a | RING_MSB;
        else if (sel_aie)
            rd_val = aux_interrupt_enable;
        else if (sel_stat)
            rd_val = aux_interrupt_status;
    end
    assign prdata = {24'h000000, rd_val};

    ////////////////////////////////////////////////////////////////////
    // Ring and pointers
    assign fifo = main_ctl[MC_FIFO_BIT];
    assign cpha = main_ctl[MC_CPHA_BIT];
    assign order = main_ctl[MC_ORDER_BIT];
    assign start_i = start_a[IW-1:0];
    assign end_i = end_a[IW-1:0];
    assign last_i = end_i - idx_type'(1);
    assign nxt_wr = adv(wr_ptr);
    assign nxt_tx = adv(tx_ptr);
    assign nxt_in = adv(in_ptr);
    assign nxt_rx = adv(rx_ptr);

    // Writes into a full ring are dropped
    assign push = w_data & fifo & (nxt_wr != rx_ptr);
    assign direct_load = w_data & ~fifo & ~hold_v;
    assign move = fifo & ~hold_v & (tx_ptr != wr_ptr) & ~w_main
        & ~tx_flush;
    // In FIFO mode, a ring full of unread receive data stalls the next byte
    assign rx_room = ~fifo | (nxt_in != rx_ptr);
    assign start_byte = (state == st_idle) & hold_v & rx_room & ~w_main
        & ~tx_flush;
    assign store = done & fifo;
    assign pop = r_data & fifo & (rx_count != 8'h00);

    // Storage has no reset; contents are don't-care until pushed
    always_ff @(posedge clk)
    begin
        if (ce && push)
            ring[wr_ptr] <= pwdata[7:0];
        if (ce && store)
            ring[in_ptr] <= rx_byte;
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            wr_ptr <= '0;
            tx_ptr <= '0;
            in_ptr <= '0;
            rx_ptr <= '0;
        end
        else if (ce)
        begin
            if (w_main)
            begin
                wr_ptr <= start_i;
                tx_ptr <= start_i;
                in_ptr <= start_i;
                rx_ptr <= start_i;
            end
            else
            begin
                if (push)
                    wr_ptr <= nxt_wr;
                if (tx_flush)
                    tx_ptr <= wr_ptr;
                else if (move)
                    tx_ptr <= nxt_tx;
                if (store)
                    in_ptr <= nxt_in;
                if (rx_flush)
                    rx_ptr <= in_ptr;
                else if (pop)
                    rx_ptr <= nxt_rx;
            end
        end
    end

    // Holding stage plus shifter give two bytes beyond the ring
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            hold_v <= 1'b0;
            hold_d <= 8'h00;
        end
        else if (ce)
        begin
            if (w_main || tx_flush)
                hold_v <= 1'b0;
            else if (move)
            begin
                hold_v <= 1'b1;
                hold_d <= ring[tx_ptr];
            end
            else if (direct_load)
            begin
                hold_v <= 1'b1;
                hold_d <= pwdata[7:0];
            end
            else if (start_byte)
                hold_v <= 1'b0;
        end
    end

    // Counters; a store in the flush cycle survives
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            tx_count <= 8'h00;
            rx_count <= 8'h00;
            rx_last <= 8'h00;
        end
        else if (ce)
        begin
            if (w_main || tx_flush)
                tx_count <= 8'h00;
            else
                tx_count <= tx_count + 8'(push | direct_load)
                    - 8'(start_byte);
            if (done)
                rx_last <= rx_byte;
            if (w_main)
                rx_count <= 8'h00;
            else if (!fifo)
                rx_count <= done ? 8'h01 : (r_data ? 8'h00 : rx_count);
            else if (rx_flush)
                rx_count <= 8'(store);
            else
                rx_count <= rx_count + 8'(store) - 8'(pop);
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Shifter, master only
    assign half = HALF_BASE << main_ctl[MC_DIV_LSB +: 3];
    assign tick = (state == st_shift) && (div_cnt == half - 8'h01);
    assign lead = tick & ~sclk_q;
    assign trail = tick & sclk_q;
    assign samp = cpha ? trail : lead;
    assign shift_ev = cpha ? (lead & (bit_cnt != 3'h0)) : trail;
    assign done = trail & (bit_cnt == 3'h7);
    assign samp_val = order ? {miso, rv[7:1]} : {rv[6:0], miso};
    assign rx_byte = cpha ? samp_val : rv;

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            state <= st_idle;
            div_cnt <= 8'h00;
            sclk_q <= 1'b0;
            bit_cnt <= 3'h0;
            sh <= 8'h00;
            rv <= 8'h00;
        end
        else if (ce)
        begin
            if (w_main)
            begin
                state <= st_idle;
                sclk_q <= 1'b0;
            end
            else
                case (state)
                    st_idle:
                        if (start_byte)
                        begin
                            state <= st_shift;
                            sh <= hold_d;
                            div_cnt <= 8'h00;
                            bit_cnt <= 3'h0;
                        end
                    st_shift:
                    begin
                        div_cnt <= tick ? 8'h00 : div_cnt + 8'h01;
                        if (tick)
                            sclk_q <= ~sclk_q;
                        if (samp)
                            rv <= samp_val;
                        if (shift_ev)
                            sh <= order ? {1'b0, sh[7:1]} : {sh[6:0], 1'b0};
                        if (trail)
                            bit_cnt <= bit_cnt + 3'h1;
                        if (done)
                            state <= st_idle;
                    end
                    default:
                        state <= st_idle;
                endcase
        end
    end

    // Select held from first byte until nothing is pending
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            ss_n <= 1'b1;
        else if (ce)
        begin
            if (w_main)
                ss_n <= 1'b1;
            else if (start_byte)
                ss_n <= 1'b0;
            else if (state == st_idle && !hold_v && tx_ptr == wr_ptr)
                ss_n <= 1'b1;
        end
    end

    assign sclk = sclk_q ^ main_ctl[MC_CPOL_BIT];
    assign mosi = order ? sh[0] : sh[7];
    assign sclk_oe = tcon[TC_SCLK_EN_BIT];
    assign mosi_oe = tcon[TC_DRV_EN_BIT];

    ////////////////////////////////////////////////////////////////////
    // Level flags, re-raised as long as the condition holds
    assign tx_lvl = {4'h0, tcon[2:0], 1'b0};
    assign rx_lvl = {5'h00, rcon[2:0]} + 8'h01;
    assign tx_flag = fifo ? (tx_count <= tx_lvl) : ~hold_v;
    assign rx_flag = fifo ? (rx_count >= rx_lvl)
        : (rx_count != 8'h00);
    assign transmit_level_irq = tx_flag;
    assign receive_level_irq = rx_flag;
    always_comb
    begin
        aux_interrupt_status = 8'h00;
        aux_interrupt_status[AI_RX_BIT] = rx_flag & aux_interrupt_enable[AI_RX_BIT];
        aux_interrupt_status[AI_TX_BIT] = tx_flag & aux_interrupt_enable[AI_TX_BIT];
    end

    ////////////////////////////////////////////////////////////////////
    sequence s_main_write;
        w_main;
    endsequence
    sequence s_quarter_gap;
        !tick ##1 tick;
    endsequence

    a_main_clears: assert property (@(posedge clk)
        disable iff (!rst_n)
        s_main_write |=> tx_count == 8'h00 && rx_count == 8'h00
            && rx_ptr == $past(start_i) && state == st_idle)
        else $error("main control write did not clear state");
    a_push_queue: assert property (@(posedge clk)
        disable iff (!rst_n)
        push && !w_main |=> wr_ptr == $past(nxt_wr)
            && ring[$past(wr_ptr)] == $past(pwdata[7:0]))
        else $error("data write not queued in ring");
    a_hold_fill: assert property (@(posedge clk) disable iff (!rst_n)
        ce && move |=> hold_v && tx_ptr == $past(nxt_tx))
        else $error("queued byte not moved to holding");
    a_store_in: assert property (@(posedge clk) disable iff (!rst_n)
        ce && store && !w_main |=> in_ptr == $past(nxt_in)
            && ring[$past(in_ptr)] == $past(rx_byte))
        else $error("received byte not stored");
    a_rx_flush: assert property (@(posedge clk) disable iff (!rst_n)
        w_rcon && pwdata[7:0] == 8'h83 && fifo |=> rx_count <= 8'h01
            && rx_ptr == $past(in_ptr) && rx_lvl == 8'h04)
        else $error("receive flush or level wrong");
    a_tx_rearm: assert property (@(posedge clk) disable iff (!rst_n)
        fifo && tx_count <= tx_lvl && !w_main && !w_tcon && !push |=>
            transmit_level_irq)
        else $error("transmit flag not held at level");
    // A main control write may stop the shifter mid-byte
    a_sclk_rate: assert property (@(posedge clk)
        disable iff (!rst_n || w_main)
        ce && tick && !done && !w_main && main_ctl[7:5] == 3'h1
            |=> s_quarter_gap)
        else $error("divider code one not clk/4");
    a_ss_steady: assert property (@(posedge clk)
        disable iff (!rst_n || w_main)
        ce && done && hold_v && !w_main && !tx_flush |=> !ss_n [*2])
        else $error("slave select toggled between bytes");
    a_ring_wrap: assert property (@(posedge clk) disable iff (!rst_n)
        push && !w_main && wr_ptr == last_i |=> wr_ptr == $past(start_i))
        else $error("write pointer did not wrap");
    a_status_code: assert property (@(posedge clk)
        disable iff (!rst_n)
        rx_flag && aux_interrupt_enable[AI_RX_BIT] && !aux_interrupt_enable[AI_TX_BIT] |-> aux_interrupt_status == 8'h04)
        else $error("receive status code wrong");
endmodule // spi_fifo_transfer_engine

// File: tb/spi_slave_model.sv
`timescale 1ns/1ps
module spi_slave_model (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic sclk,
    input wire logic mosi,
    input wire logic ss_n,
    output logic miso,
    output int got_count
);
    logic [7:0] got [0:63];
    logic [7:0] tx_sh;
    logic [7:0] rx_sh;
    logic sclk_q;
    int bit_cnt;
    ////////////////////////////////////////////////////////////////
    // Mode 1 slave: drive on rising edge, sample on falling edge
    always @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            sclk_q <= 1'b0;
            miso <= 1'b0;
            got_count <= 0;
            bit_cnt <= 0;
            tx_sh <= 8'h50;
        end
        else
        begin
            sclk_q <= sclk;
            if (ss_n)
            begin
                // Undriven line: toggles so a stale value never matches
                miso <= ~miso;
                bit_cnt <= 0;
                tx_sh <= 8'h50 + 8'(got_count);
            end
            else if (sclk && !sclk_q)
            begin
                miso <= tx_sh[7];
                tx_sh <= {tx_sh[6:0], 1'b0};
            end
            else if (!sclk && sclk_q)
            begin
                rx_sh <= {rx_sh[6:0], mosi};
                bit_cnt <= (bit_cnt == 7) ? 0 : bit_cnt + 1;
                if (bit_cnt == 7)
                begin
                    got[got_count[5:0]] <= {rx_sh[6:0], mosi};
                    got_count <= got_count + 1;
                    tx_sh <= 8'h51 + 8'(got_count);
                end
            end
        end
    end
endmodule // spi_slave_model

// File: tb/testbench.sv
`timescale 1ns/1ps
module testbench;
    import spi_fifo_pkg::*;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [PADDR_W-1:0] paddr = '0;
    logic [31:0] pwdata = '0;
    logic pready, pslverr, sclk, sclk_oe, mosi, mosi_oe, miso, ss_n;
    logic [31:0] prdata;
    logic transmit_level_irq, receive_level_irq;
    logic [31:0] rd;
    logic err;
    logic ss_prev = 1'b1;
    int got_count, fail_count, tests_run, ss_rises, cycles, n, hp;
    logic [2:0] hp_codes [0:2] = '{3'h1, 3'h3, 3'h7};
    always #2.5 clk = ~clk;
    spi_fifo_transfer_engine #(.RING_DEPTH(RING_DEPTH_DEF)) DUT (
        .clk(clk), .rst_n(rst_n), .ce(1'b1), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .pready(pready), .prdata(prdata),
        .pslverr(pslverr), .sclk(sclk), .sclk_oe(sclk_oe), .mosi(mosi),
        .mosi_oe(mosi_oe), .miso(miso), .ss_n(ss_n),
        .transmit_level_irq(transmit_level_irq),
        .receive_level_irq(receive_level_irq));
    spi_slave_model u_slave (.clk(clk), .rst_n(rst_n), .sclk(sclk),
        .mosi(mosi), .ss_n(ss_n), .miso(miso), .got_count(got_count));
    ////////////////////////////////////////////////////////////////
    always @(posedge clk)
    begin
        ss_prev <= ss_n;
        if (!ss_prev && ss_n)
            ss_rises <= ss_rises + 1;
        cycles <= cycles + 1;
        // Whole run needs well under this many cycles
        if (cycles == 40000)
        begin
            fail_count++;
            stop_test();
        end
    end
    task automatic stop_test();
        $display("Checks %0d, mismatches %0d", tests_run, fail_count);
        if (fail_count == 0 && tests_run > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    task automatic check(input string name, input logic [31:0] seen,
                         input logic [31:0] exp);
        tests_run++;
        if (seen !== exp)
        begin
            fail_count++;
            $display("[FAIL] %s expected %h seen %h", name, exp, seen);
        end
    endtask
    // Read data and error are taken at the edge that sees pready high
    task automatic apb(input logic wr, input logic [7:0] idx,
                       input logic [31:0] wd);
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= {2'b00, idx, 2'b00};
        pwdata <= wd;
        @(posedge clk);
        penable <= 1'b1;
        @(posedge clk);
        while (pready !== 1'b1)
            @(posedge clk);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wr(input logic [7:0] idx, input logic [7:0] d);
        apb(1'b1, idx, {24'h0, d});
    endtask
    task automatic rdchk(input string name, input logic [7:0] idx,
                         input logic [31:0] exp);
        apb(1'b0, idx, 32'h0);
        check(name, rd, exp);
    endtask
    task automatic wait_got(input int target);
        for (int i = 0; i < 20000 && got_count < target; i++)
            @(posedge clk);
    endtask
    task automatic wait_rx_flag();
        for (int i = 0; i < 400 && receive_level_irq !== 1'b1; i++)
            @(negedge clk);
    endtask
    ////////////////////////////////////////////////////////////////
    initial
    begin
        repeat (16) @(posedge clk);
        rst_n <= 1'b1;
        @(negedge clk);
        check("tx irq reset", transmit_level_irq, 1'b1);
        check("rx irq reset", receive_level_irq, 1'b0);
        wr(IDX_AIE, 8'h0c);
        rdchk("status idle", IDX_AUX_INTERRUPT_STATUS, 32'h08);
        apb(1'b0, 8'h10, 32'h0);
        check("unmapped err", err, 1'b1);
        // Same setup as a typical interrupt-driven fifo transfer
        wr(IDX_RCON, 8'h83);
        wr(IDX_TCON, 8'haa);
        wr(IDX_START, 8'h00);
        wr(IDX_END, 8'h08);
        wr(IDX_MAIN, 8'h36);
        rdchk("start", IDX_START, 32'h80);
        rdchk("end", IDX_END, 32'h88);
        @(negedge clk);
        check("mosi oe", mosi_oe, 1'b1);
        check("sclk oe", sclk_oe, 1'b1);
        check("tx irq empty", transmit_level_irq, 1'b1);
        n = ss_rises;
        for (int i = 0; i < 4; i++)
            wr(IDX_DATA, 8'ha0 + 8'(i));
        wait_got(4);
        wait_rx_flag();
        for (int i = 0; i < 4; i++)
            check("sent", u_slave.got[i], 8'ha0 + 8'(i));
        check("ss held", ss_rises - n <= 1, 1'b1);
        check("rx irq four", receive_level_irq, 1'b1);
        wr(IDX_AIE, 8'h04);
        rdchk("status rx", IDX_AUX_INTERRUPT_STATUS, 32'h04);
        wr(IDX_AIE, 8'h0c);
        rdchk("status both", IDX_AUX_INTERRUPT_STATUS, 32'h0c);
        // Drain what came back so transmission keeps going
        for (int i = 0; i < 4; i++)
            rdchk("received", IDX_DATA, 32'h50 + 32'(i));
        @(negedge clk);
        check("rx irq drained", receive_level_irq, 1'b0);
        // Second batch runs the pointers past the ring end
        for (int i = 0; i < 6; i++)
            wr(IDX_DATA, 8'hb0 + 8'(i));
        @(negedge clk);
        check("tx irq above", transmit_level_irq, 1'b0);
        wait_got(10);
        wait_rx_flag();
        for (int i = 0; i < 6; i++)
            check("wrap sent", u_slave.got[4+i], 8'hb0 + 8'(i));
        rdchk("wrap rx0", IDX_DATA, 32'h54);
        rdchk("wrap rx1", IDX_DATA, 32'h55);
        wr(IDX_RCON, 8'h83);
        @(negedge clk);
        check("rx flushed", receive_level_irq, 1'b0);
        rdchk("status flushed", IDX_AUX_INTERRUPT_STATUS, 32'h08);
        for (int i = 0; i < 6; i++)
            wr(IDX_DATA, 8'hc0 + 8'(i));
        n = got_count;
        wr(IDX_TCON, 8'haa);
        @(negedge clk);
        check("tx flushed irq", transmit_level_irq, 1'b1);
        repeat (300) @(posedge clk);
        check("tx flushed", got_count - n <= 2, 1'b1);
        for (int i = 0; i < 3; i++)
            wr(IDX_DATA, 8'hd0 + 8'(i));
        wr(IDX_MAIN, 8'h36);
        n = got_count;
        repeat (300) @(posedge clk);
        check("main reset", got_count, n);
        check("main ss", ss_n, 1'b1);
        check("main tx irq", transmit_level_irq, 1'b1);
        // Half period of the serial clock per divider code
        foreach (hp_codes[k])
        begin
            wr(IDX_MAIN, {hp_codes[k], 5'h16});
            wr(IDX_DATA, 8'h3c);
            for (int i = 0; i < 3000 && sclk !== 1'b1; i++)
                @(posedge clk);
            hp = 0;
            for (int i = 0; i < 3000 && sclk === 1'b1; i++)
            begin
                @(posedge clk);
                hp++;
            end
            check("half period", hp, 1 << hp_codes[k]);
            for (int i = 0; i < 5000 && ss_n !== 1'b1; i++)
                @(posedge clk);
        end
        check("plain byte", u_slave.got[got_count-1], 8'h3c);
        // Smallest ring, least significant bit first
        wr(IDX_START, 8'h10);
        wr(IDX_END, 8'h12);
        wr(IDX_MAIN, 8'h3e);
        n = got_count;
        wr(IDX_DATA, 8'h12);
        wait_got(n + 1);
        check("lsb first", u_slave.got[n], 8'h48);
        stop_test();
    end
endmodule // testbench
